// >>> hdl/rsbs_defs.svh
// Register offsets, field positions, reset values and timing counts of the sequencer
`ifndef RSBS_DEFS_SVH
`define RSBS_DEFS_SVH
`define RSBS_OFF_MODE       12'h000
`define RSBS_OFF_STATUS     12'h004
`define RSBS_OFF_CAUSE      12'h008
`define RSBS_OFF_SMON       12'h00C
`define RSBS_OFF_CLOCK      12'h010
`define RSBS_OFF_NVCMD      12'h014
`define RSBS_OFF_RSTCTL     12'h018
`define RSBS_OFF_TICKCAL    12'h01C
`define RSBS_MODE_BOD_DIS   0
`define RSBS_MODE_XTAL_EN   1
`define RSBS_MODE_XTAL_SEL  2
`define RSBS_MODE_SWRST     3
`define RSBS_MODE_RESET     32'h0000_0000
`define RSBS_SMON_EN        4
`define RSBS_SMON_SMPL      5
`define RSBS_SMON_RESET     32'h0000_0000
`define RSBS_CLK_RESET      32'h0000_0000
`define RSBS_NVCMD_SET      8
`define RSBS_NVCMD_CLR      9
`define RSBS_BOOT_BIT       1
`define RSBS_BOOT_VECTOR    32'h0000_0000
`define RSBS_TICK_CAL       32'h0000_1F40
`define RSBS_SLOW_HZ        32768
`define RSBS_CORE_HZ        250000000
`define RSBS_SLOW_DIV       (`RSBS_CORE_HZ / `RSBS_SLOW_HZ)
`define RSBS_STEP_SLOW      4
`define RSBS_PULSE_SLOW     8
`define RSBS_SMPL_MAX       2048
`endif

// >>> hdl/rsbs_pkg.sv
// Types shared by the reset, supply and boot sequencer
`default_nettype none
package rsbs_pkg;
   typedef enum logic [2:0] {
      rsbs_st_off    = 3'b000,
      rsbs_st_switch = 3'b001,
      rsbs_st_regul  = 3'b011,
      rsbs_st_run    = 3'b010
   } rsbs_seq_type;
   typedef enum logic [2:0] {
      rsbs_cause_general = 3'd0,
      rsbs_cause_wakeup  = 3'd1,
      rsbs_cause_soft    = 3'd2,
      rsbs_cause_user    = 3'd3,
      rsbs_cause_wdog    = 3'd4
   } rsbs_cause_type;
   typedef enum logic [1:0] {
      rsbs_frc_4  = 2'd0,
      rsbs_frc_8  = 2'd1,
      rsbs_frc_12 = 2'd2
   } rsbs_frc_type;
endpackage
`default_nettype wire

// >>> hdl/rsbs_sequencer.sv
// Reset, supply supervision, startup clock and boot selection block
//
// Function
// - Processor fetches its first vector at address zero after every reset.
// - Boot bit one set maps flash at zero; clear maps ROM, the default.
// - Flash command unit offers separate set and clear of the boot bit.
// - Erase input forces boot bit one clear, so next boot is ROM.
// - I/O supply power-on monitor always active; low supply resets whole chip.
// - Core brownout detector on after reset; off only by mode register write.
// - Enabled brownout plus low core supply asserts core reset.
// - I/O supply monitor off after reset, software enabled, 16 threshold steps.
// - Sampled monitor mode powers it periodically, dividing consumption up to 2048.
// - Last reset source readable: general, wake-up, software, user, watchdog.
// - External reset pin sensed and driven; pulse shaped for a push-button.
// - Reset manager configuration lives on I/O supply, survives core loss.
// - Supply sequencer runs on 32 kHz slow clock with own power-on reset.
// - Slow clock starts on RC; software may enable and select crystal.
// - Slow RC oscillator is disabled automatically once crystal is selected.
// - Startup enables power switches, then regulator, then releases core resets.
// - Fast RC offers 4, 8, 12 MHz; 4 MHz after reset.
// - Master clock starts on fast RC default until software reprograms it.
// - Tick timer calibration register returns fixed 8000.
`include "rsbs_defs.svh"
`default_nettype none
module rsbs_sequencer #(
   parameter int unsigned SLOW_DIV = `RSBS_SLOW_DIV
) (
   input  wire logic        core_clk,         // 250 MHz clock
   input  wire logic        resetn,           // Power-on reset of io supply, async
   input  wire logic        psel,             // APB select
   input  wire logic        penable,          // APB enable
   input  wire logic        pwrite,           // APB direction
   input  wire logic [11:0] paddr,            // APB byte address
   input  wire logic [31:0] pwdata,           // APB write data
   output logic      [31:0] prdata,           // APB read data
   output logic             pready,           // APB ready
   output logic             pslverr,          // APB error
   input  wire logic        core_low,         // Core supply under threshold
   input  wire logic        io_low,           // Io supply under monitor threshold
   input  wire logic        erase_pin,        // Erase input pin
   input  wire logic        wakeup_req,       // Wake-up reset request
   input  wire logic        wdog_req,         // Watchdog reset request
   input  wire logic        ext_reset_pin_n_i, // External reset pin level
   output logic             ext_reset_pin_n_o, // External reset pin drive value
   output logic             ext_reset_pin_n_oe_n, // Pin drive enable, low drives
   output logic             power_switch_en,  // Internal power switches on
   output logic             regulator_en,     // Voltage regulator on
   output logic             core_resetn,      // Core domain reset, low active
   output logic             bod_en,           // Brownout detector enable
   output logic             smon_en,          // Supply monitor powered
   output logic      [3:0]  smon_thresh,      // Supply monitor threshold step
   output logic             rc_osc_en,        // Slow RC oscillator enable
   output logic             xtal_osc_en,      // Slow crystal oscillator enable
   output logic             slow_sel_xtal,    // Slow clock from crystal
   output logic      [1:0]  fast_rc_freq,     // Fast RC frequency select
   output logic      [1:0]  master_clk_src,   // Master clock source select
   output logic             boot_flash,       // Flash mapped at boot address
   output logic      [31:0] boot_vector       // First fetch address
);
   // ------------------------------------------------------------
   // Reset release and input synchronisers
   // ------------------------------------------------------------
   logic [1:0] rst_sync;
   logic       rst_n;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) rst_sync <= 2'b00;
      else rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_n = rst_sync[1];

   logic [5:0] in_s1;
   logic [5:0] in_s2;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         in_s1 <= 6'b01_0000;
         in_s2 <= 6'b01_0000;
      end else begin
         in_s1 <= {core_low, ext_reset_pin_n_i, io_low, erase_pin, wakeup_req, wdog_req};
         in_s2 <= in_s1;
      end
   end

   // ------------------------------------------------------------
   // Slow clock enable from divider
   // ------------------------------------------------------------
   logic [15:0] div_cnt;
   logic        slow_tick;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt   <= 16'h0000;
         slow_tick <= 1'b0;
      end else if (div_cnt == 16'(SLOW_DIV - 1)) begin
         div_cnt   <= 16'h0000;
         slow_tick <= 1'b1;
      end else begin
         div_cnt   <= div_cnt + 16'h0001;
         slow_tick <= 1'b0;
      end
   end

   // Sources sampled on the slow tick, glitches falling between two ticks ignored
   logic [5:0] slow_in;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) slow_in <= 6'b01_0000;
      else if (slow_tick) slow_in <= in_s2;
   end
   logic core_low_s, pin_n_s, io_low_s, erase_s, wake_s, wdog_s;
   assign {core_low_s, pin_n_s, io_low_s, erase_s, wake_s, wdog_s} = slow_in;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [31:0] mode_reg;
   logic [31:0] smon_reg;
   logic [31:0] clk_reg;
   logic [7:0]  pulse_len;
   logic        wr_en;
   logic        rd_en;
   logic        addr_ok;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;

   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == `RSBS_OFF_MODE) || (a == `RSBS_OFF_STATUS) ||
                  (a == `RSBS_OFF_CAUSE) || (a == `RSBS_OFF_SMON) ||
                  (a == `RSBS_OFF_CLOCK) || (a == `RSBS_OFF_NVCMD) ||
                  (a == `RSBS_OFF_RSTCTL) || (a == `RSBS_OFF_TICKCAL);
   endfunction
   assign addr_ok = is_mapped(paddr);

   logic soft_req;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg <= `RSBS_MODE_RESET;
         soft_req <= 1'b0;
      end else begin
         soft_req <= wr_en && (paddr == `RSBS_OFF_MODE) && pwdata[`RSBS_MODE_SWRST];
         if (wr_en && paddr == `RSBS_OFF_MODE) begin
            mode_reg <= {29'h0, pwdata[2:0]};
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) smon_reg <= `RSBS_SMON_RESET;
      else if (wr_en && paddr == `RSBS_OFF_SMON) smon_reg <= {16'h0, pwdata[15:0]};
   end

   // Master clock selection persists until software rewrites it
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) clk_reg <= `RSBS_CLK_RESET;
      else if (wr_en && paddr == `RSBS_OFF_CLOCK) begin
         clk_reg <= {28'h0, pwdata[3:2], (pwdata[1:0] == 2'b11) ? 2'b00 : pwdata[1:0]};
      end
   end

   // Pin pulse length lives in the io supply domain with resetn only
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) pulse_len <= 8'(`RSBS_PULSE_SLOW);
      else if (wr_en && paddr == `RSBS_OFF_RSTCTL && pwdata[7:0] != 8'h00) begin
         pulse_len <= pwdata[7:0];
      end
   end

   // ------------------------------------------------------------
   // Boot configuration bit
   // ------------------------------------------------------------
   logic nv_bit;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) nv_bit <= 1'b0;
      else if (erase_s) nv_bit <= 1'b0;
      else if (wr_en && paddr == `RSBS_OFF_NVCMD && pwdata[7:0] == 8'(`RSBS_BOOT_BIT)) begin
         if (pwdata[`RSBS_NVCMD_CLR]) nv_bit <= 1'b0;
         else if (pwdata[`RSBS_NVCMD_SET]) nv_bit <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Supply sequencer
   // ------------------------------------------------------------
   rsbs_pkg::rsbs_seq_type state;
   logic [3:0] step_cnt;
   logic       core_rst_req;
   logic       bod_fire;
   logic       pin_low_req;
   logic       user_req;
   logic       stretch_act;
   assign bod_fire = !mode_reg[`RSBS_MODE_BOD_DIS] && core_low_s;
   assign user_req = !pin_n_s && !stretch_act;
   // Core stays in reset for as long as the pin pulse lasts
   assign core_rst_req = bod_fire || soft_req || user_req || wake_s || wdog_s || stretch_act;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state    <= rsbs_pkg::rsbs_st_off;
         step_cnt <= 4'h0;
      end else if (core_rst_req && state == rsbs_pkg::rsbs_st_run) begin
         state    <= rsbs_pkg::rsbs_st_regul;
         step_cnt <= 4'h0;
      end else if (slow_tick) begin
         case (state)
            rsbs_pkg::rsbs_st_off: begin
               state <= rsbs_pkg::rsbs_st_switch;
            end
            rsbs_pkg::rsbs_st_switch: begin
               if (step_cnt == 4'(`RSBS_STEP_SLOW - 1)) begin
                  state    <= rsbs_pkg::rsbs_st_regul;
                  step_cnt <= 4'h0;
               end else step_cnt <= step_cnt + 4'h1;
            end
            rsbs_pkg::rsbs_st_regul: begin
               if (core_rst_req) step_cnt <= 4'h0;
               else if (step_cnt == 4'(`RSBS_STEP_SLOW - 1)) begin
                  state    <= rsbs_pkg::rsbs_st_run;
                  step_cnt <= 4'h0;
               end else step_cnt <= step_cnt + 4'h1;
            end
            rsbs_pkg::rsbs_st_run: state <= rsbs_pkg::rsbs_st_run;
            default: state <= rsbs_pkg::rsbs_st_off;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Reset cause, latched in io domain at each release
   // ------------------------------------------------------------
   rsbs_pkg::rsbs_cause_type cause;
   rsbs_pkg::rsbs_cause_type pend_cause;
   logic                     pend_valid;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pend_cause <= rsbs_pkg::rsbs_cause_general;
         pend_valid <= 1'b0;
      end else if (state == rsbs_pkg::rsbs_st_run && core_rst_req && !pend_valid) begin
         pend_valid <= 1'b1;
         if (wdog_s) pend_cause <= rsbs_pkg::rsbs_cause_wdog;
         else if (soft_req) pend_cause <= rsbs_pkg::rsbs_cause_soft;
         else if (user_req) pend_cause <= rsbs_pkg::rsbs_cause_user;
         else if (wake_s) pend_cause <= rsbs_pkg::rsbs_cause_wakeup;
         else pend_cause <= rsbs_pkg::rsbs_cause_general;
      end else if (core_resetn == 1'b0 && state == rsbs_pkg::rsbs_st_run) begin
         pend_valid <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) cause <= rsbs_pkg::rsbs_cause_general;
      else if (!core_resetn && state == rsbs_pkg::rsbs_st_run) begin
         cause <= pend_valid ? pend_cause : rsbs_pkg::rsbs_cause_general;
      end
   end

   // ------------------------------------------------------------
   // External reset pin shaping
   // ------------------------------------------------------------
   // Every reset source in run shapes a pulse on the pin
   logic [7:0] stretch_cnt;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         stretch_cnt <= 8'h00;
         stretch_act <= 1'b0;
      end else if (state == rsbs_pkg::rsbs_st_run && core_rst_req && !stretch_act) begin
         stretch_cnt <= pulse_len;
         stretch_act <= 1'b1;
      end else if (slow_tick && stretch_act) begin
         if (stretch_cnt != 8'h00) stretch_cnt <= stretch_cnt - 8'h01;
         else if (pin_n_s) stretch_act <= 1'b0;
      end
   end
   // Drive low for the programmed ticks, then wait with drive off until
   // the pin reads high, so own drive or a held button never retriggers
   assign pin_low_req = stretch_act && (stretch_cnt != 8'h00);

   // ------------------------------------------------------------
   // Sampled supply monitor
   // ------------------------------------------------------------
   logic [11:0] smpl_cnt;
   logic        smpl_on;
   logic [11:0] smpl_period;
   assign smpl_period = 12'(16 << smon_reg[8:6]);   // 16..2048 slow cycles
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         smpl_cnt <= 12'h000;
         smpl_on  <= 1'b0;
      end else if (slow_tick) begin
         if (smpl_cnt >= smpl_period - 12'h001) begin
            smpl_cnt <= 12'h000;
            smpl_on  <= 1'b1;
         end else begin
            smpl_cnt <= smpl_cnt + 12'h001;
            smpl_on  <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         power_switch_en      <= 1'b0;
         regulator_en         <= 1'b0;
         core_resetn          <= 1'b0;
         bod_en               <= 1'b1;
         smon_en              <= 1'b0;
         smon_thresh          <= 4'h0;
         rc_osc_en            <= 1'b1;
         xtal_osc_en          <= 1'b0;
         slow_sel_xtal        <= 1'b0;
         fast_rc_freq         <= 2'b00;
         master_clk_src       <= 2'b00;
         boot_flash           <= 1'b0;
         boot_vector          <= `RSBS_BOOT_VECTOR;
         ext_reset_pin_n_o    <= 1'b0;
         ext_reset_pin_n_oe_n <= 1'b1;
      end else begin
         power_switch_en <= state != rsbs_pkg::rsbs_st_off;
         regulator_en    <= state == rsbs_pkg::rsbs_st_regul || state == rsbs_pkg::rsbs_st_run;
         core_resetn     <= state == rsbs_pkg::rsbs_st_run && !core_rst_req;
         bod_en          <= !mode_reg[`RSBS_MODE_BOD_DIS];
         smon_en         <= smon_reg[`RSBS_SMON_EN] &&
                            (!smon_reg[`RSBS_SMON_SMPL] || smpl_on);
         smon_thresh     <= smon_reg[3:0];
         slow_sel_xtal   <= mode_reg[`RSBS_MODE_XTAL_SEL] && mode_reg[`RSBS_MODE_XTAL_EN];
         xtal_osc_en     <= mode_reg[`RSBS_MODE_XTAL_EN];
         rc_osc_en       <= !(mode_reg[`RSBS_MODE_XTAL_SEL] && mode_reg[`RSBS_MODE_XTAL_EN]);
         fast_rc_freq    <= clk_reg[1:0];
         master_clk_src  <= clk_reg[3:2];
         if (!core_resetn) boot_flash <= nv_bit;
         boot_vector     <= `RSBS_BOOT_VECTOR;
         ext_reset_pin_n_o    <= 1'b0;
         ext_reset_pin_n_oe_n <= !pin_low_req;
      end
   end

   // ------------------------------------------------------------
   // APB slave, zero wait states
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !is_mapped(paddr);
         prdata  <= 32'h0000_0000;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               `RSBS_OFF_MODE:    prdata <= mode_reg;
               `RSBS_OFF_STATUS:  prdata <= {24'h0, nv_bit, boot_flash, io_low_s,
                                             core_low_s, 1'b0, state};
               `RSBS_OFF_CAUSE:   prdata <= {29'h0, cause};
               `RSBS_OFF_SMON:    prdata <= smon_reg;
               `RSBS_OFF_CLOCK:   prdata <= clk_reg;
               `RSBS_OFF_RSTCTL:  prdata <= {24'h0, pulse_len};
               `RSBS_OFF_TICKCAL: prdata <= `RSBS_TICK_CAL;
               default:           prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   logic unused_ok;
   assign unused_ok = addr_ok & rd_en;
endmodule // rsbs_sequencer
`default_nettype wire

// >>> testbench/rsbs_sequencer_props.sv
// Concurrent checks on the ports of the reset, supply and boot sequencer
`include "rsbs_defs.svh"
`default_nettype none
module rsbs_sequencer_props #(
   parameter int unsigned SLOW_DIV = 4 // Core cycles per slow tick
) (
   input wire logic        core_clk,             // Clock
   input wire logic        resetn,               // Power-on reset
   input wire logic        psel,                 // APB select
   input wire logic        penable,              // APB enable
   input wire logic        pwrite,               // APB direction
   input wire logic [11:0] paddr,                // APB address
   input wire logic [31:0] prdata,               // APB read data
   input wire logic        pready,               // APB ready
   input wire logic        core_low,             // Core supply low
   input wire logic        ext_reset_pin_n_o,    // Pin drive value
   input wire logic        ext_reset_pin_n_oe_n, // Pin drive enable
   input wire logic        power_switch_en,      // Power switches
   input wire logic        regulator_en,         // Regulator
   input wire logic        core_resetn,          // Core reset
   input wire logic        bod_en,               // Brownout enable
   input wire logic        rc_osc_en,            // Slow RC on
   input wire logic        xtal_osc_en,          // Crystal on
   input wire logic        slow_sel_xtal,        // Crystal selected
   input wire logic [1:0]  fast_rc_freq,         // Fast RC select
   input wire logic [31:0] boot_vector           // First fetch address
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // ----------
   // Properties
   // ----------
   property p_vec; boot_vector == `RSBS_BOOT_VECTOR; endproperty
   a_vec: assert property (p_vec) else $error("Boot vector not zero");
   property p_seq; $rose(regulator_en) |-> power_switch_en; endproperty
   a_seq: assert property (p_seq) else $error("Regulator before switches");
   property p_rel; $rose(core_resetn) |-> power_switch_en && regulator_en; endproperty
   a_rel: assert property (p_rel) else $error("Core released early");
   property p_bod; core_low && bod_en |-> ##[1:16] !core_resetn; endproperty
   a_bod: assert property (p_bod) else $error("Brownout ignored");
   property p_osc;
      slow_sel_xtal && $past(slow_sel_xtal, 12) |-> xtal_osc_en && !rc_osc_en;
   endproperty
   a_osc: assert property (p_osc) else $error("Unused slow oscillator on");
   property p_pin; $fell(ext_reset_pin_n_oe_n) |-> !ext_reset_pin_n_oe_n [*8]; endproperty
   a_pin: assert property (p_pin) else $error("Pin pulse too short");
   property p_cal;
      psel && !penable && !pwrite && paddr == `RSBS_OFF_TICKCAL |=> prdata == `RSBS_TICK_CAL;
   endproperty
   a_cal: assert property (p_cal) else $error("Calibration value wrong");
   property p_frc; fast_rc_freq != 2'd3; endproperty
   a_frc: assert property (p_frc) else $error("Fast RC code illegal");
   property p_rdy; psel && !penable |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("Register access not answered");
endmodule // rsbs_sequencer_props
bind rsbs_sequencer rsbs_sequencer_props #(.SLOW_DIV(SLOW_DIV)) rsbs_sequencer_props_i (
   .core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .core_low,
   .ext_reset_pin_n_o, .ext_reset_pin_n_oe_n, .power_switch_en, .regulator_en, .core_resetn,
   .bod_en, .rc_osc_en, .xtal_osc_en, .slow_sel_xtal, .fast_rc_freq, .boot_vector);
`default_nettype wire

// >>> testbench/rsbs_pin_model.sv
// External reset pin with pull-up and push-button
`default_nettype none
module rsbs_pin_model (
   input wire logic  pin_o,     // Device drive value
   input wire logic  pin_oe_n,  // Device drive enable, low drives
   input wire logic  button_n,  // Push-button, low pressed
   output logic      pin_level  // Resolved pin level
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pull-up wins unless device or button pulls low
   assign pin_level = ((!pin_oe_n && !pin_o) || !button_n) ? 1'b0 : 1'b1;
endmodule // rsbs_pin_model
`default_nettype wire

// >>> testbench/rsbs_sequencer_test.sv
// Self-checking bench of the reset, supply and boot sequencer
`include "rsbs_defs.svh"
`default_nettype none
module rsbs_sequencer_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, core_low = 0;
   logic io_low = 0, erase_pin = 0, wakeup_req = 0, wdog_req = 0, button_n = 1;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, boot_vector, r;
   logic pready, pslverr, ext_reset_pin_n_i, ext_reset_pin_n_o, ext_reset_pin_n_oe_n;
   logic power_switch_en, regulator_en, core_resetn, bod_en, smon_en, rc_osc_en;
   logic xtal_osc_en, slow_sel_xtal, boot_flash, lerr;
   logic [3:0] smon_thresh;
   logic [1:0] fast_rc_freq, master_clk_src;
   int n_mismatch = 0, n_compared = 0;
   rsbs_sequencer #(.SLOW_DIV(4)) rsbs_sequencer_i (.core_clk, .resetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .core_low, .io_low, .erase_pin,
      .wakeup_req, .wdog_req, .ext_reset_pin_n_i, .ext_reset_pin_n_o, .ext_reset_pin_n_oe_n,
      .power_switch_en, .regulator_en, .core_resetn, .bod_en, .smon_en, .smon_thresh,
      .rc_osc_en, .xtal_osc_en, .slow_sel_xtal, .fast_rc_freq, .master_clk_src, .boot_flash,
      .boot_vector);
   rsbs_pin_model rsbs_pin_model_i (.pin_o(ext_reset_pin_n_o), .pin_oe_n(ext_reset_pin_n_oe_n),
      .button_n, .pin_level(ext_reset_pin_n_i));
   always #2 core_clk = ~core_clk;
   // -------------
   // Shared tasks
   // -------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge core_clk);
      penable <= 1;
      do @(posedge core_clk); while (pready !== 1'b1);
      r = prdata; lerr = pslverr; psel <= 0; penable <= 0;
      repeat (2) @(posedge core_clk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
      apb(0, a, 0);
      chk(r & m, exp);
   endtask
   task automatic wait_core(input logic v);
      int n = 0;
      while (core_resetn !== v && n < 400) begin @(posedge core_clk); n++; end
      chk({31'b0, core_resetn}, {31'b0, v});
   endtask
   // -------------
   // Scenarios
   // -------------
   task automatic t_start;
      chk({bod_en, smon_en, rc_osc_en, xtal_osc_en, fast_rc_freq, master_clk_src}, 8'hA0);
      wait_core(1);
      chk({power_switch_en, regulator_en}, 2'b11);
      rd(`RSBS_OFF_CAUSE, rsbs_pkg::rsbs_cause_general, 32'h7);
      $display("startup done");
   endtask
   task automatic t_regs;
      rd(`RSBS_OFF_TICKCAL, 32'h0000_1F40, 32'hFFFF_FFFF);
      rd(12'h020, 32'h0, 32'hFFFF_FFFF);
      chk({31'b0, lerr}, 32'h1);
      apb(1, `RSBS_OFF_CLOCK, 32'h3);
      rd(`RSBS_OFF_CLOCK, 32'h0, 32'h3);
      apb(1, `RSBS_OFF_CLOCK, 32'h2);
      chk({fast_rc_freq, master_clk_src}, 4'h8);
      apb(1, `RSBS_OFF_CLOCK, 32'h0);
      chk({fast_rc_freq, master_clk_src}, 4'h0);
      apb(1, `RSBS_OFF_SMON, 32'h1FF);
      rd(`RSBS_OFF_SMON, 32'h1FF, 32'h1FF);
      chk(smon_thresh, 4'hF);
      io_low <= 1;
      repeat (8) @(posedge core_clk);
      rd(`RSBS_OFF_STATUS, 32'h20, 32'h20);
      io_low <= 0;
      $display("registers done");
   endtask
   task automatic t_boot;
      apb(1, `RSBS_OFF_NVCMD, 32'h101);
      rd(`RSBS_OFF_STATUS, 32'h80, 32'h80);
      apb(1, `RSBS_OFF_MODE, 32'h8);
      wait_core(0);
      wait_core(1);
      chk({31'b0, boot_flash}, 32'h1);
      chk(boot_vector, `RSBS_BOOT_VECTOR);
      rd(`RSBS_OFF_CAUSE, rsbs_pkg::rsbs_cause_soft, 32'h7);
      erase_pin <= 1;
      repeat (20) @(posedge core_clk);
      erase_pin <= 0;
      rd(`RSBS_OFF_STATUS, 32'h0, 32'h80);
      apb(1, `RSBS_OFF_NVCMD, 32'h101);
      apb(1, `RSBS_OFF_NVCMD, 32'h201);
      rd(`RSBS_OFF_STATUS, 32'h0, 32'h80);
      $display("boot done");
   endtask
   task automatic t_causes;
      rsbs_pkg::rsbs_cause_type ex[4] = '{rsbs_pkg::rsbs_cause_wakeup,
         rsbs_pkg::rsbs_cause_wdog, rsbs_pkg::rsbs_cause_user, rsbs_pkg::rsbs_cause_general};
      for (int i = 0; i < 4; i++) begin
         case (i)
            0: wakeup_req <= 1;
            1: wdog_req <= 1;
            2: button_n <= 0;
            default: core_low <= 1;
         endcase
         repeat (20) @(posedge core_clk);
         chk({31'b0, core_resetn}, 32'h0);
         chk({31'b0, ext_reset_pin_n_oe_n}, 32'h0);
         wakeup_req <= 0; wdog_req <= 0; button_n <= 1; core_low <= 0;
         wait_core(1);
         rd(`RSBS_OFF_CAUSE, ex[i], 32'h7);
      end
      $display("causes done");
   endtask
   task automatic t_mode;
      apb(1, `RSBS_OFF_MODE, 32'h1);
      chk({31'b0, bod_en}, 32'h0);
      core_low <= 1;
      repeat (40) @(posedge core_clk);
      chk({31'b0, core_resetn}, 32'h1);
      core_low <= 0;
      repeat (8) @(posedge core_clk);
      apb(1, `RSBS_OFF_MODE, 32'h6);
      repeat (16) @(posedge core_clk);
      chk({slow_sel_xtal, xtal_osc_en, rc_osc_en, bod_en}, 4'hD);
      resetn <= 0;
      #1 chk({31'b0, core_resetn}, 32'h0);
      repeat (3) @(posedge core_clk);
      resetn <= 1;
      wait_core(1);
      chk({rc_osc_en, slow_sel_xtal, bod_en}, 3'b101);
      rd(`RSBS_OFF_CAUSE, rsbs_pkg::rsbs_cause_general, 32'h7);
      $display("mode done");
   endtask
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      // Erase input held low through startup
      erase_pin = 0;
      repeat (20) @(posedge core_clk);
      resetn <= 1;
      t_start;
      t_regs;
      t_boot;
      t_causes;
      t_mode;
      finish_test;
   end
   initial begin
      #100000;
      n_mismatch++;
      finish_test;
   end
endmodule // rsbs_sequencer_test
`default_nettype wire
